/* File: tec_evt_src.sv */
`timescale 1ns/1ps
module tec_evt_src (
   input wire logic ref_clk,
   output logic     evt
);
   initial evt = 1'b0;
   task automatic burst(input int n, input int gap);
      repeat (n) begin
         evt = ~evt;
         repeat (gap) @(negedge ref_clk);
      end
   endtask
endmodule // tec_evt_src

/* File: tec_pkg.sv */
package tec_pkg;
   // mode register field positions
   localparam int MODE_COUNT_EN = 7;
   localparam int MODE_PWM      = 6;
   localparam int MODE_PRESET_S = 3;
   localparam int MODE_PRESET_C = 2;
   localparam int MODE_INV_LVL  = 1;
   localparam int MODE_OUT_EN   = 0;
   localparam logic [7:0] MODE_RESET  = 8'h00;
   localparam logic [7:0] CMP_RESET   = 8'h00;
   localparam logic [2:0] CKSEL_RESET = 3'h0;
   localparam logic [7:0] COUNT_ZERO  = 8'h00;
   localparam logic [7:0] COUNT_TOP   = 8'hFF;
   // clock-select codes: 0/1 pick event-pin edges, rest divide ref_clk
   localparam logic [2:0] SEL_EVT_FALL = 3'h0;
   localparam logic [2:0] SEL_EVT_RISE = 3'h1;
   localparam int PRESCALE_W = 12;
   typedef enum logic [1:0] {TEC_IDLE, TEC_RUN} tec_state_t;
endpackage

/* File: tec_tick_gen.sv */
`timescale 1ns/1ps
// count-clock tick generator: prescaled ref_clk or event-pin edge
module tec_tick_gen (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic event_input_pin,
   tec_tick_if.src   tk
);
   logic [tec_pkg::PRESCALE_W-1:0] div_r, div_nxt;
   logic                           evtPrev_r, evtPrev_nxt;
   logic                           tick_r, tick_nxt;

   always_comb begin
      div_nxt     = tk.run ? div_r + 1'b1 : '0;
      evtPrev_nxt = event_input_pin;
      case (tk.sel)
         tec_pkg::SEL_EVT_FALL: tick_nxt = tk.run & evtPrev_r & ~event_input_pin;
         tec_pkg::SEL_EVT_RISE: tick_nxt = tk.run & ~evtPrev_r & event_input_pin;
         3'h2:    tick_nxt = tk.run & (div_r[1:0] == 2'h3);
         3'h3:    tick_nxt = tk.run & (div_r[3:0] == 4'hF);
         3'h4:    tick_nxt = tk.run & (div_r[5:0] == 6'h3F);
         3'h5:    tick_nxt = tk.run & (div_r[7:0] == 8'hFF);
         3'h6:    tick_nxt = tk.run & (div_r[9:0] == 10'h3FF);
         default: tick_nxt = tk.run & (&div_r);
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         div_r     <= '0;
         evtPrev_r <= 1'b0;
         tick_r    <= 1'b0;
      end else begin
         div_r     <= div_nxt;
         evtPrev_r <= evtPrev_nxt;
         tick_r    <= tick_nxt;
      end
   end

   assign tk.tick = tick_r;
endmodule // tec_tick_gen

/* File: tec_tick_if.sv */
`timescale 1ns/1ps
interface tec_tick_if;
   logic       tick;
   logic [2:0] sel;
   logic       run;
   modport src (output tick, input sel, input run);
   modport dst (input tick, output sel, output run);
endinterface

/* File: tec_timer.sv */
`timescale 1ns/1ps
// Summary of operation
// - clear-and-start mode: match clears counter to 00H next count, pulses interrupt
// - count-enable 1 starts counting, 0 stops and clears
// - event counting: select 00H falling edge, 01H rising edge of event pin
// - three-bit count clock select field, bits 0 to 2
// - square-wave mode: with mode bit 1 set, output flip-flop toggles on each match, 50% duty
// - square-wave frequency is 1/(2t(N+1)), N from 00H to FFH
// - mode bit 6 set selects PWM free-running operation
// - PWM: mode bit 1 selects active-high (0) or active-low (1)
// - PWM: mode bit 0 enables waveform on timer output
// - PWM inactive until overflow, active until match, repeating
// - PWM output goes inactive immediately when counting stops
// - PWM period 256 count clocks, active width N clocks
// - PWM compare buffered; written before FFH edge loads next overflow
// - compare read returns newly written value while transfer pending
// - start is asynchronous to count clock; first match may slip one clock
// - output-enable 0 drives timer output low
module tec_timer (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       event_input_pin,
   input  wire logic       mode_wr,
   input  wire logic [7:0] mode_wdata,
   input  wire logic       cmp_wr,
   input  wire logic [7:0] cmp_wdata,
   input  wire logic       cksel_wr,
   input  wire logic [2:0] cksel_wdata,
   output logic      [7:0] timer_mode_reg,
   output logic      [7:0] compare_value_reg,
   output logic      [2:0] count_clock_select_reg,
   output logic      [7:0] event_counter_value,
   output logic            match_interrupt_request,
   output logic            timer_output_pin
);
   tec_tick_if tk ();

   // mode and run state
   logic [7:0]          mode_r, mode_nxt;
   logic [2:0]          cksel_r, cksel_nxt;
   tec_pkg::tec_state_t state_r, state_nxt;
   // counter
   logic [7:0]          cnt_r, cnt_nxt;
   // compare buffering
   logic [7:0]          cmpWr_r, cmpWr_nxt;     // software view of compare
   logic [7:0]          cmpAct_r, cmpAct_nxt;   // value in effect
   logic                pend_r, pend_nxt;
   logic                armed_r, armed_nxt;     // pending value moves at the next overflow
   // output and interrupt
   logic                ff_r, ff_nxt;
   logic                pwmAct_r, pwmAct_nxt;
   logic                irq_r, irq_nxt;
   logic                out_r, out_nxt;

   logic                run;
   logic                pwm;
   logic                atTop;
   logic                match;
   logic                ovf;
   logic                pwmEnd;

   tec_tick_gen u_tick (
      .ref_clk         (ref_clk),
      .nrst            (nrst),
      .event_input_pin (event_input_pin),
      .tk              (tk.src)
   );

   assign tk.sel = cksel_r;
   assign tk.run = mode_nxt[tec_pkg::MODE_COUNT_EN];

   // conditions shared by the counter, compare and output groups
   always_comb begin
      run    = (state_r == tec_pkg::TEC_RUN);
      pwm    = mode_r[tec_pkg::MODE_PWM];
      atTop  = (cnt_r == tec_pkg::COUNT_TOP);
      match  = run & tk.tick & (cnt_r == cmpAct_r);
      ovf    = run & tk.tick & atTop;
      // counter reaches the compare value on this tick: ends the active phase after N clocks
      pwmEnd = run & tk.tick & ((cnt_r + 8'h01) == cmpAct_r);
   end

   // mode, clock select and run state
   always_comb begin
      mode_nxt  = mode_r;
      cksel_nxt = cksel_r;
      state_nxt = state_r;
      if (mode_wr) begin
         // preset bits are write-only strobes, bits 5 and 4 read 0
         mode_nxt = mode_wdata & 8'hC3;
      end
      if (cksel_wr) begin
         cksel_nxt = cksel_wdata;
      end
      case (state_r)
         tec_pkg::TEC_IDLE: begin
            // start is taken on ref_clk, not on a count tick
            if (mode_nxt[tec_pkg::MODE_COUNT_EN]) begin
               state_nxt = tec_pkg::TEC_RUN;
            end
         end
         tec_pkg::TEC_RUN: begin
            if (!mode_nxt[tec_pkg::MODE_COUNT_EN]) begin
               state_nxt = tec_pkg::TEC_IDLE;
            end
         end
         default: begin
            state_nxt = tec_pkg::TEC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         mode_r  <= tec_pkg::MODE_RESET;
         cksel_r <= tec_pkg::CKSEL_RESET;
         state_r <= tec_pkg::TEC_IDLE;
      end else begin
         mode_r  <= mode_nxt;
         cksel_r <= cksel_nxt;
         state_r <= state_nxt;
      end
   end

   // counter
   always_comb begin
      cnt_nxt = cnt_r;
      if (!run) begin
         cnt_nxt = tec_pkg::COUNT_ZERO;
      end else if (tk.tick) begin
         if (!pwm && (cnt_r == cmpAct_r)) begin
            cnt_nxt = tec_pkg::COUNT_ZERO;
         end else begin
            // free-running wrap at FFH gives the 256-clock PWM period
            cnt_nxt = cnt_r + 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cnt_r <= tec_pkg::COUNT_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // compare buffering
   always_comb begin
      cmpWr_nxt  = cmpWr_r;
      cmpAct_nxt = cmpAct_r;
      pend_nxt   = pend_r;
      armed_nxt  = armed_r;
      if (pend_r && ovf) begin
         if (armed_r) begin
            cmpAct_nxt = cmpWr_r;
            pend_nxt   = 1'b0;
            armed_nxt  = 1'b0;
         end else begin
            // written after the FFH edge: this overflow only arms it
            armed_nxt = 1'b1;
         end
      end
      if (cmp_wr) begin
         cmpWr_nxt = cmp_wdata;
         if (pwm && run) begin
            pend_nxt  = 1'b1;
            // counter already standing at FFH: the coming overflow is too close
            armed_nxt = !atTop || tk.tick;
         end else begin
            cmpAct_nxt = cmp_wdata;
            pend_nxt   = 1'b0;
            armed_nxt  = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cmpWr_r  <= tec_pkg::CMP_RESET;
         cmpAct_r <= tec_pkg::CMP_RESET;
         pend_r   <= 1'b0;
         armed_r  <= 1'b0;
      end else begin
         cmpWr_r  <= cmpWr_nxt;
         cmpAct_r <= cmpAct_nxt;
         pend_r   <= pend_nxt;
         armed_r  <= armed_nxt;
      end
   end

   // output flip-flop, pwm phase, pin and interrupt
   always_comb begin
      ff_nxt = ff_r;
      if (mode_wr && !mode_wdata[tec_pkg::MODE_PWM]) begin
         // preset code 11 is refused and leaves the flip-flop alone
         if (mode_wdata[tec_pkg::MODE_PRESET_S] && !mode_wdata[tec_pkg::MODE_PRESET_C]) begin
            ff_nxt = 1'b1;
         end else if (!mode_wdata[tec_pkg::MODE_PRESET_S] && mode_wdata[tec_pkg::MODE_PRESET_C]) begin
            ff_nxt = 1'b0;
         end
      end else if (match && !pwm && mode_r[tec_pkg::MODE_INV_LVL]) begin
         ff_nxt = ~ff_r;
      end
      pwmAct_nxt = pwmAct_r;
      if (!run || !pwm) begin
         pwmAct_nxt = 1'b0;
      end else if (ovf) begin
         // judged on the value in effect after any transfer; 00H stays inactive
         pwmAct_nxt = (cmpAct_nxt != tec_pkg::COUNT_ZERO);
      end else if (pwmEnd) begin
         pwmAct_nxt = 1'b0;
      end
      if (!mode_nxt[tec_pkg::MODE_OUT_EN]) begin
         out_nxt = 1'b0;
      end else if (mode_nxt[tec_pkg::MODE_PWM]) begin
         out_nxt = (pwmAct_nxt & mode_nxt[tec_pkg::MODE_COUNT_EN]) ^ mode_nxt[tec_pkg::MODE_INV_LVL];
      end else begin
         out_nxt = ff_nxt;
      end
      irq_nxt = match;
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ff_r     <= 1'b0;
         pwmAct_r <= 1'b0;
         irq_r    <= 1'b0;
         out_r    <= 1'b0;
      end else begin
         ff_r     <= ff_nxt;
         pwmAct_r <= pwmAct_nxt;
         irq_r    <= irq_nxt;
         out_r    <= out_nxt;
      end
   end

   assign timer_mode_reg          = mode_r;
   assign compare_value_reg       = cmpWr_r;
   assign count_clock_select_reg  = cksel_r;
   assign event_counter_value     = cnt_r;
   assign match_interrupt_request = irq_r;
   assign timer_output_pin        = out_r;
endmodule // tec_timer

/* File: tec_timer_assertions.sv */
`timescale 1ns/1ps
module tec_timer_assertions (
   input wire logic       ref_clk,
   input wire logic       nrst,
   input wire logic       cmp_wr,
   input wire logic [7:0] cmp_wdata,
   input wire logic [7:0] timer_mode_reg,
   input wire logic [7:0] compare_value_reg,
   input wire logic [7:0] event_counter_value,
   input wire logic       match_interrupt_request,
   input wire logic       timer_output_pin
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   wire logic [7:0] mode = timer_mode_reg, cmp = compare_value_reg, cnt = event_counter_value;
   wire logic irq = match_interrupt_request, pin = timer_output_pin, pwmIdle = mode[6] & mode[0] & ~mode[7];
   sequence pwm_run_s; mode[7] && mode[6]; endsequence
   irq_pulse_a: assert property (irq |=> !irq) else $error("irq too long");
   irq_clear_a: assert property (irq && !mode[6] |-> cnt == 8'h00) else $error("no clear on match");
   stop_clear_a: assert property (!$past(mode[7]) |-> cnt == 8'h00) else $error("stopped counter moved");
   pwm_count_a: assert property (pwm_run_s ##0 $changed(cnt) |-> cnt == $past(cnt)+8'h01) else $error("skip");
   out_off_a: assert property (!mode[0] |-> !pin) else $error("pin not low");
   pwm_stop_a: assert property (pwmIdle |-> pin == mode[1]) else $error("pwm not idle");
   sq_toggle_a: assert property (!mode[6] && mode[7] && $changed(pin) |-> irq || $past(irq)) else $error("stray");
   cmp_read_a: assert property ($past(cmp_wr) |-> cmp == $past(cmp_wdata)) else $error("cmp readback");
endmodule // tec_timer_assertions
bind tec_timer tec_timer_assertions u_chk (
   .ref_clk                 (ref_clk),
   .nrst                    (nrst),
   .cmp_wr                  (cmp_wr),
   .cmp_wdata               (cmp_wdata),
   .timer_mode_reg          (timer_mode_reg),
   .compare_value_reg       (compare_value_reg),
   .event_counter_value     (event_counter_value),
   .match_interrupt_request (match_interrupt_request),
   .timer_output_pin        (timer_output_pin)
);

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic       ref_clk, nrst, event_input_pin, mode_wr, cmp_wr, cksel_wr, match_interrupt_request, timer_output_pin, o;
   logic [7:0] mode_wdata, cmp_wdata, timer_mode_reg, compare_value_reg, event_counter_value;
   logic [2:0] cksel_wdata, count_clock_select_reg;
   int         n_mismatch, n_tests, c;
   tec_timer u_dut (
      .ref_clk                 (ref_clk),
      .nrst                    (nrst),
      .event_input_pin         (event_input_pin),
      .mode_wr                 (mode_wr),
      .mode_wdata              (mode_wdata),
      .cmp_wr                  (cmp_wr),
      .cmp_wdata               (cmp_wdata),
      .cksel_wr                (cksel_wr),
      .cksel_wdata             (cksel_wdata),
      .timer_mode_reg          (timer_mode_reg),
      .compare_value_reg       (compare_value_reg),
      .count_clock_select_reg  (count_clock_select_reg),
      .event_counter_value     (event_counter_value),
      .match_interrupt_request (match_interrupt_request),
      .timer_output_pin        (timer_output_pin)
   );
   tec_evt_src u_src (.ref_clk(ref_clk), .evt(event_input_pin));
   always #2.5 ref_clk = ~ref_clk;
   task chk(input logic [15:0] s, e);
      n_tests++;
      if (s !== e) $display("MISMATCH %0t got %h want %h", $time, s, e);
      n_mismatch += int'(s !== e);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task wr(input int k, input logic [7:0] d);
      @(negedge ref_clk);
      {mode_wdata, cmp_wdata, cksel_wdata} = {d, d, d[2:0]};
      {cksel_wr, cmp_wr, mode_wr} = 3'h1 << k;
      @(negedge ref_clk);
      {cksel_wr, cmp_wr, mode_wr} = 3'h0;
   endtask
   // w 0 waits for a match pulse, otherwise for an output edge; n is the wait in cycles
   task wt(input int w, output int n);
      for (n = 1, o = timer_output_pin; n < 3000; n++) begin
         @(negedge ref_clk);
         if (w == 0 ? match_interrupt_request === 1'b1 : timer_output_pin !== o) return;
      end
      n_mismatch++;
      print_verdict();
   endtask
   initial begin
      {ref_clk, nrst, mode_wr, cmp_wr, cksel_wr, mode_wdata, cmp_wdata, cksel_wdata} = 24'h00_0000;
      repeat (16) @(negedge ref_clk);
      nrst = 1'b1;
      wr(2, 8'h02);
      wr(1, 8'h03);
      wr(0, 8'h80);
      chk(timer_mode_reg, 8'h80);
      chk(count_clock_select_reg, 3'h2);
      wt(0, c);
      wt(0, c);
      chk(c[15:0], 16'h0010);
      for (int p = 0; p < 2; p++) begin
         wr(0, p ? 8'h0B : 8'h07);
         repeat (2) @(negedge ref_clk);
         chk(timer_output_pin, p[0]);
         chk(timer_mode_reg, 8'h03);
         wr(0, 8'h83);
         wt(1, c);
         wt(1, c);
         chk(c[15:0], 16'h0010);
         wr(0, 8'h00);
      end
      // five edges from alternating start levels: only the chosen edge may count
      for (int i = 0; i < 2; i++) begin
         wr(2, 8'(i));
         wr(0, 8'h80);
         chk(count_clock_select_reg, 3'(i));
         u_src.burst(5, 8);
         chk(event_counter_value, 8'h02);
         wr(0, 8'h00);
      end
      wr(1, 8'h40);
      wr(2, 8'h02);
      for (int v = 0; v < 2; v++) begin
         wr(0, v ? 8'h43 : 8'h41);
         wr(0, v ? 8'hC3 : 8'hC1);
         wt(1, c);
         wt(1, c);
         chk(c[15:0], v ? 16'h0200 : 16'h0100);
         wt(1, c);
         chk(c[15:0], v ? 16'h0200 : 16'h0300);
         wr(1, 8'h80);
         chk(compare_value_reg, 8'h80);
      end
      // reset in mid-run: every output returns to its reset value
      @(negedge ref_clk);
      nrst = 1'b0;
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk({timer_mode_reg, compare_value_reg}, 16'h0000);
      chk({event_counter_value, 5'h00, count_clock_select_reg}, 16'h0000);
      chk({14'h0000, timer_output_pin, match_interrupt_request}, 16'h0000);
      print_verdict();
   end
endmodule // testbench
